// >>> hdl/addr_map_pkg.sv
// Address map constants and carrier types for the system address decoder
// Behaviour
// - Route 0x4000_0000..0x5FFF_FFFF to peripherals
// - Core aligned word-size alias accesses become bit operations
// - Non-core alias access gives bus error
// - Low peripheral megabyte goes through APB bridge; the code routes only its window hits there, the rest gets no target
// - External RAM region has no target
// - External device region has no target
// - Private peripheral region is core only
// - Private region needs privileged mode
// - Vendor region has no target
// - Fetch port serves code via cache
// - Code data port reaches flash and info
// - System port reaches SRAM, APB, AHB areas
// - DMA reaches off-core areas, not private
// - Register address is base plus offset
// - Control, interface, function windows 1KB each
// - Two low-power timers in 4KB windows
// - Low-power UART in 4KB window
// - AES memory mapped on AHB
package addr_map_pkg;

  // ****************************************
  // Requesters and targets
  // ****************************************
  typedef enum logic [1:0] {
    REQ_ICODE,
    REQ_DCODE,
    REQ_SYS,
    REQ_DMA
  } requester_t;

  typedef enum logic [3:0] {
    TGT_NONE,
    TGT_CACHE,
    TGT_FLASH,
    TGT_INFO,
    TGT_SRAM,
    TGT_AES_MEM,
    TGT_AHB_PERIPH,
    TGT_APB,
    TGT_PRIVATE
  } target_t;

  typedef enum logic [3:0] {
    APB_NONE,
    APB_GLOBAL_CONTROL,
    APB_SYSTEM_INTERFACE,
    APB_FUNCTION_CONTROL,
    APB_LP_TIMER_A,
    APB_LP_TIMER_B,
    APB_LP_UART
  } apb_sel_t;

  typedef struct packed {
    logic valid;
    requester_t src;
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic privileged;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    target_t target;
    apb_sel_t apb_sel;
    logic [31:0] addr;
    logic [19:0] offset;
    logic write;
    logic bitband;
    logic [4:0] bit_pos;
    logic error;
  } route_t;

  // ****************************************
  // Regions
  // ****************************************
  localparam logic [31:0] CODE_BASE = 32'h0000_0000;
  localparam logic [31:0] CODE_END = 32'h1FFF_FFFF;
  localparam logic [31:0] INFO_BASE = 32'h1000_0000;
  localparam logic [31:0] INFO_END = 32'h1000_7FFF;
  localparam logic [31:0] FLASH_END = 32'h0005_FFFF;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_END = 32'h3FFF_FFFF;
  localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] PERIPH_END = 32'h5FFF_FFFF;
  localparam logic [31:0] APB_END = 32'h400F_FFFF;
  localparam logic [31:0] ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] ALIAS_END = 32'h43FF_FFFF;
  localparam logic [31:0] AES_MEM_BASE = 32'h4800_0000;
  localparam logic [31:0] AES_MEM_END = 32'h4800_0FFF;
  localparam logic [31:0] EXT_RAM_BASE = 32'h6000_0000;
  localparam logic [31:0] EXT_RAM_END = 32'h9FFF_FFFF;
  localparam logic [31:0] EXT_DEV_BASE = 32'hA000_0000;
  localparam logic [31:0] EXT_DEV_END = 32'hDFFF_FFFF;
  localparam logic [31:0] PRIV_BASE = 32'hE000_0000;
  localparam logic [31:0] PRIV_END = 32'hE00F_FFFF;
  localparam logic [31:0] VENDOR_BASE = 32'hE010_0000;
  localparam logic [31:0] VENDOR_END = 32'hFFFF_FFFF;

  // ****************************************
  // APB windows
  // ****************************************
  localparam int APB_WIN_COUNT = 6;
  localparam logic [31:0] WIN_1K_SIZE = 32'h0000_0400;
  localparam logic [31:0] WIN_4K_SIZE = 32'h0000_1000;
  localparam logic [31:0] GLOBAL_CONTROL_WINDOW = 32'h4000_0000;
  localparam logic [31:0] SYSTEM_INTERFACE_WINDOW = 32'h4000_0400;
  localparam logic [31:0] FUNCTION_CONTROL_WINDOW = 32'h4000_0800;
  localparam logic [31:0] LOW_POWER_TIMER_A_WINDOW = 32'h4011_4000;
  localparam logic [31:0] LOW_POWER_TIMER_B_WINDOW = 32'h4011_5000;
  localparam logic [31:0] LOW_POWER_UART_WINDOW = 32'h4014_5000;

  // Bit-band alias split: byte index and bit number
  localparam int ALIAS_BIT_LSB = 2;
  localparam int ALIAS_BYTE_LSB = 5;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [31:0] APB_BASES [APB_WIN_COUNT] = '{
    GLOBAL_CONTROL_WINDOW, SYSTEM_INTERFACE_WINDOW, FUNCTION_CONTROL_WINDOW,
    LOW_POWER_TIMER_A_WINDOW, LOW_POWER_TIMER_B_WINDOW,
    LOW_POWER_UART_WINDOW
  };
  localparam logic [31:0] APB_SIZES [APB_WIN_COUNT] = '{
    WIN_1K_SIZE, WIN_1K_SIZE, WIN_1K_SIZE,
    WIN_4K_SIZE, WIN_4K_SIZE, WIN_4K_SIZE
  };
  localparam apb_sel_t APB_SELS [APB_WIN_COUNT] = '{
    APB_GLOBAL_CONTROL, APB_SYSTEM_INTERFACE, APB_FUNCTION_CONTROL,
    APB_LP_TIMER_A, APB_LP_TIMER_B, APB_LP_UART
  };

endpackage

// >>> hdl/apb_window_decode.sv
// APB peripheral window decoder
`timescale 1ns/1ps
module apb_window_decode
  import addr_map_pkg::*;
(
  input wire logic [31:0] addr,
  output apb_sel_t sel,
  output logic [19:0] offset,
  output logic hit
);

  logic [APB_WIN_COUNT-1:0] match;

  // One comparator pair per window
  genvar g;
  generate
    for (g = 0; g < APB_WIN_COUNT; g++) begin : g_win
      assign match[g] = (addr >= APB_BASES[g]) &&
                        (addr <= APB_BASES[g] + APB_SIZES[g] - 32'h0000_0001);
    end
  endgenerate

  always_comb begin
    sel = APB_NONE;
    offset = 20'h0_0000;
    hit = 1'b0;
    for (int i = 0; i < APB_WIN_COUNT; i++) begin
      if (match[i]) begin
        sel = APB_SELS[i];
        offset = 20'(addr - APB_BASES[i]);
        hit = 1'b1;
      end
    end
  end

endmodule

// >>> hdl/region_classify.sv
// Region classifier for one bus request
`timescale 1ns/1ps
module region_classify
  import addr_map_pkg::*;
(
  input wire logic [31:0] addr,
  output logic in_code,
  output logic in_flash,
  output logic in_info,
  output logic in_sram,
  output logic in_periph,
  output logic in_apb,
  output logic in_alias,
  output logic in_aes,
  output logic in_priv,
  output logic in_unimpl
);

  always_comb begin
    in_code = addr <= CODE_END;
    in_flash = addr <= FLASH_END;
    in_info = (addr >= INFO_BASE) && (addr <= INFO_END);
    in_sram = (addr >= SRAM_BASE) && (addr <= SRAM_END);
    in_periph = (addr >= PERIPH_BASE) && (addr <= PERIPH_END);
    in_apb = (addr >= PERIPH_BASE) && (addr <= APB_END);
    in_alias = (addr >= ALIAS_BASE) && (addr <= ALIAS_END);
    in_aes = (addr >= AES_MEM_BASE) && (addr <= AES_MEM_END);
    in_priv = (addr >= PRIV_BASE) && (addr <= PRIV_END);
    in_unimpl = ((addr >= EXT_RAM_BASE) && (addr <= EXT_RAM_END)) ||
                ((addr >= EXT_DEV_BASE) && (addr <= EXT_DEV_END)) ||
                (addr >= VENDOR_BASE);
  end

endmodule

// >>> hdl/system_address_decoder.sv
// System address decoder: classifies, checks and routes one request a cycle
`timescale 1ns/1ps
module system_address_decoder
  import addr_map_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire bus_req_t REQ,
  output route_t ROUTE
);

  // ****************************************
  // Classification
  // ****************************************
  logic in_code, in_flash, in_info, in_sram, in_periph, in_apb;
  logic in_alias, in_aes, in_priv, in_unimpl;
  apb_sel_t apb_sel;
  logic [19:0] apb_off;
  logic apb_hit;
  logic [31:0] bb_addr;
  logic is_core;
  route_t route_r, route_nxt;

  region_classify u_class (
    .addr(REQ.addr),
    .in_code(in_code),
    .in_flash(in_flash),
    .in_info(in_info),
    .in_sram(in_sram),
    .in_periph(in_periph),
    .in_apb(in_apb),
    .in_alias(in_alias),
    .in_aes(in_aes),
    .in_priv(in_priv),
    .in_unimpl(in_unimpl)
  );

  // Alias word maps to byte in base area; bit-band is resolved here
  assign bb_addr = PERIPH_BASE |
    {12'h000, REQ.addr[24:ALIAS_BYTE_LSB]};

  apb_window_decode u_apb (
    .addr(REQ.addr),
    .sel(apb_sel),
    .offset(apb_off),
    .hit(apb_hit)
  );

  assign is_core = REQ.src != REQ_DMA;

  // ****************************************
  // Route decision
  // ****************************************
  always_comb begin
    route_nxt = '0;
    route_nxt.valid = REQ.valid;
    route_nxt.addr = REQ.addr;
    route_nxt.write = REQ.write;
    route_nxt.target = TGT_NONE;
    route_nxt.apb_sel = APB_NONE;
    if (REQ.valid) begin
      case (REQ.src)
        REQ_ICODE: begin
          if (in_code) begin
            route_nxt.target = TGT_CACHE;
          end
        end
        REQ_DCODE: begin
          if (in_info) begin
            route_nxt.target = TGT_INFO;
          end else if (in_flash) begin
            route_nxt.target = TGT_FLASH;
          end
        end
        REQ_SYS, REQ_DMA: begin
          if (in_sram) begin
            route_nxt.target = TGT_SRAM;
          end else if (in_alias) begin
            // Only the core remaps; others see a hole
            if (is_core && REQ.size == SIZE_WORD &&
                REQ.addr[1:0] == 2'h0) begin
              route_nxt.target = TGT_APB;
              route_nxt.bitband = 1'b1;
              route_nxt.addr = {bb_addr[31:2], 2'h0};
              route_nxt.bit_pos = REQ.addr[6:ALIAS_BIT_LSB];
              route_nxt.offset = bb_addr[19:0];
            end
          end else if (apb_hit) begin
            // Bridge windows also sit above the low megabyte
            route_nxt.target = TGT_APB;
            route_nxt.apb_sel = apb_sel;
            route_nxt.offset = apb_off;
          end else if (in_aes) begin
            route_nxt.target = TGT_AES_MEM;
          end else if (in_periph && !in_apb) begin
            route_nxt.target = TGT_AHB_PERIPH;
          end else if (in_priv) begin
            if (REQ.src == REQ_SYS && REQ.privileged) begin
              route_nxt.target = TGT_PRIVATE;
            end
          end else if (in_unimpl) begin
            route_nxt.target = TGT_NONE;
          end
        end
        default: begin
          route_nxt.target = TGT_NONE;
        end
      endcase
      // Error answer and no strobe to any target
      route_nxt.error = route_nxt.target == TGT_NONE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      route_r <= '0;
    end else begin
      route_r <= route_nxt;
    end
  end

  assign ROUTE = route_r;

endmodule

// >>> tb/requester_model.sv
// Requester model for the core bus ports and the DMA engine
`timescale 1ns/1ps
module requester_model
  import addr_map_pkg::*;
(
  input wire logic clk,
  output bus_req_t req
);
  initial req = '0;
  // Word size so that core alias accesses qualify for bit operations
  task automatic issue(input requester_t src, input logic [31:0] addr,
      input logic priv);
    @(posedge clk);
    req <= '{valid: 1'b1, src: src, addr: addr, write: addr[3],
      size: SIZE_WORD, privileged: priv};
  endtask
endmodule

// >>> tb/system_address_decoder_bench.sv
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
module system_address_decoder_bench;
  import addr_map_pkg::*;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  bus_req_t REQ;
  route_t ROUTE;
  int err_total = 0;
  int num_checks = 0;
  always #20 CLK = ~CLK;
  requester_model i_requester_model (.clk(CLK), .req(REQ));
  system_address_decoder i_system_address_decoder (.CLK(CLK),
    .RST_B(RST_B), .REQ(REQ), .ROUTE(ROUTE));
  // ****************************************
  // Checks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Answer is registered, so judge 1 ns after the edge that takes the request
  task automatic rt(input requester_t s, input logic [31:0] a,
      input target_t t, input apb_sel_t sel = APB_NONE,
      input logic [19:0] off = 20'h0_0000, input logic p = 1'b1);
    i_requester_model.issue(s, a, p);
    @(posedge CLK);
    #1;
    chk("target", 32'(ROUTE.target), 32'(t));
    chk("error", 32'(ROUTE.error), 32'(t == TGT_NONE));
    chk("valid", 32'(ROUTE.valid), 32'h0000_0001);
    chk("addr", ROUTE.addr, a);
    chk("write", 32'(ROUTE.write), 32'(a[3]));
    chk("bitband", 32'(ROUTE.bitband), 32'h0000_0000);
    if (t == TGT_APB) begin
      chk("apb_sel", 32'(ROUTE.apb_sel), 32'(sel));
      chk("offset", 32'(ROUTE.offset), 32'(off));
    end
  endtask
  task automatic t_apb();
    rt(REQ_SYS, 32'h4000_03FF, TGT_APB, APB_GLOBAL_CONTROL, 20'h0_03FF);
    rt(REQ_SYS, 32'h4000_0400, TGT_APB, APB_SYSTEM_INTERFACE);
    rt(REQ_DMA, 32'h4000_0BFC, TGT_APB, APB_FUNCTION_CONTROL,
      20'h0_03FC);
    rt(REQ_SYS, 32'h4011_4FFC, TGT_APB, APB_LP_TIMER_A, 20'h0_0FFC);
    rt(REQ_DMA, 32'h4011_5000, TGT_APB, APB_LP_TIMER_B);
    rt(REQ_SYS, 32'h4014_5FFF, TGT_APB, APB_LP_UART, 20'h0_0FFF);
    rt(REQ_SYS, 32'h4014_6000, TGT_AHB_PERIPH);
    rt(REQ_SYS, 32'h4000_0C00, TGT_NONE);
  endtask
  task automatic t_unmapped();
    rt(REQ_SYS, 32'h6000_0000, TGT_NONE);
    rt(REQ_DMA, 32'h9FFF_FFFC, TGT_NONE);
    rt(REQ_SYS, 32'hA000_0000, TGT_NONE);
    rt(REQ_DMA, 32'hDFFF_FFFC, TGT_NONE);
    rt(REQ_SYS, 32'hE010_0000, TGT_NONE);
    rt(REQ_SYS, 32'hFFFF_FFFC, TGT_NONE);
  endtask
  task automatic t_private();
    rt(REQ_SYS, 32'hE000_E010, TGT_PRIVATE);
    rt(REQ_SYS, 32'hE00F_FFFC, TGT_NONE, APB_NONE, 20'h0_0000, 1'b0);
    rt(REQ_DMA, 32'hE000_E010, TGT_NONE);
    rt(REQ_DMA, 32'h2000_0100, TGT_SRAM);
    rt(REQ_SYS, 32'h2000_0100, TGT_SRAM);
    rt(REQ_SYS, 32'h4800_0010, TGT_AES_MEM);
  endtask
  task automatic t_code();
    rt(REQ_ICODE, 32'h0000_0100, TGT_CACHE);
    rt(REQ_ICODE, 32'h0005_FFFC, TGT_CACHE);
    rt(REQ_DCODE, 32'h0000_1000, TGT_FLASH);
    rt(REQ_DCODE, 32'h1000_0010, TGT_INFO);
  endtask
  task automatic t_alias();
    i_requester_model.issue(REQ_SYS, 32'h4200_0084, 1'b1);
    @(posedge CLK);
    #1;
    chk("bitband", 32'(ROUTE.bitband), 32'h0000_0001);
    chk("bit_pos", 32'(ROUTE.bit_pos), 32'h0000_0001);
    chk("bb_target", 32'(ROUTE.target), 32'(TGT_APB));
    chk("bb_addr", ROUTE.addr, 32'h4000_0004);
    chk("bb_offset", 32'(ROUTE.offset), 32'h0000_0004);
    chk("bb_error", 32'(ROUTE.error), 32'h0000_0000);
    rt(REQ_DMA, 32'h4200_0084, TGT_NONE);
    rt(REQ_SYS, 32'h4200_0086, TGT_NONE);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run is about sixty cycles
  initial begin
    repeat (2000) @(posedge CLK);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    t_apb();
    t_unmapped();
    t_private();
    t_code();
    t_alias();
    give_verdict();
  end
endmodule
bind system_address_decoder system_address_decoder_checker
  i_system_address_decoder_checker (.CLK(CLK), .RST_B(RST_B), .REQ(REQ),
  .ROUTE(ROUTE));

// >>> tb/system_address_decoder_checker.sv
// Assertion checker for the system address decoder
`timescale 1ns/1ps
module system_address_decoder_checker
  import addr_map_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire bus_req_t REQ,
  input wire route_t ROUTE
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_alias_core;
    REQ.valid && REQ.src == REQ_SYS && REQ.addr[31:25] == 7'h21 &&
      REQ.addr[1:0] == 2'h0 && REQ.size == SIZE_WORD;
  endsequence
  sequence s_refused;
    ROUTE.error && ROUTE.target == TGT_NONE;
  endsequence
  a_ext_ram_err: assert property (REQ.valid && REQ.addr inside
    {[EXT_RAM_BASE:EXT_RAM_END]} |=> s_refused) else $error("ext ram");
  a_ext_dev_err: assert property (REQ.valid && REQ.addr inside
    {[EXT_DEV_BASE:EXT_DEV_END]} |=> s_refused) else $error("ext dev");
  a_vendor_err: assert property (REQ.valid && REQ.addr inside
    {[VENDOR_BASE:VENDOR_END]} |=> s_refused) else $error("vendor");
  a_dma_private: assert property (REQ.valid && REQ.src == REQ_DMA &&
    REQ.addr inside {[PRIV_BASE:PRIV_END]} |=> s_refused)
    else $error("dma private");
  a_unpriv_refuse: assert property (REQ.valid && !REQ.privileged &&
    REQ.addr inside {[PRIV_BASE:PRIV_END]} |=> s_refused)
    else $error("unprivileged");
  a_alias_dma: assert property (REQ.valid && REQ.src == REQ_DMA &&
    REQ.addr[31:25] == 7'h21 |=> s_refused ##0 !ROUTE.bitband)
    else $error("dma alias");
  a_alias_bit: assert property (s_alias_core |=> ROUTE.bitband &&
    ROUTE.bit_pos == $past(REQ.addr[6:2])) else $error("alias bit");
  a_fetch_cache: assert property (REQ.valid && REQ.src == REQ_ICODE &&
    REQ.addr <= FLASH_END |=> ROUTE.target == TGT_CACHE)
    else $error("fetch");
  a_global_win: assert property (REQ.valid && REQ.src == REQ_SYS &&
    REQ.addr[31:10] == GLOBAL_CONTROL_WINDOW[31:10] |=>
    ROUTE.target == TGT_APB && ROUTE.apb_sel == APB_GLOBAL_CONTROL &&
    ROUTE.offset == {10'h000, $past(REQ.addr[9:0])}) else $error("global");
  a_uart_win: assert property (REQ.valid && REQ.src == REQ_SYS &&
    REQ.addr[31:12] == LOW_POWER_UART_WINDOW[31:12] |=>
    ROUTE.target == TGT_APB && ROUTE.apb_sel == APB_LP_UART)
    else $error("uart window");
endmodule
